// >>> dirctl_top.sv
// half-duplex rs-232 to rs-485 direction controller
// Operation
// R1: auto mode: start bit enables driver, ten-bit idle disables
// R2: manual mode: driver follows host rts
// R3: rs-485 receive activity drops cts
// R4: cts returns after ten idle bit periods
// R5: host data during holdoff returns cts immediately
// R6: rate code selects 300 to 38400 bit/s
// R7: start-stop half duplex, one direction at once
// R8: topology selector: off four-wire, on two-wire
// R9: mode selector: off automatic, on manual
// R10: echo selector: off disabled, on enabled, two-wire only
// R11: configurer keeps echo off in four-wire
// R12: rate code defaults to 5 after reset
// R13: driver indicator equals driver enable
// R14: receive indicator lit while host rx carries data
// R15: ready indicator lit while out of reset
// R16: echo passes own traffic; else rx blocked while driving
// R17: timeouts count clock cycles, restart on edges
`timescale 1ns/1ps
`default_nettype none
module dirctl_top (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // switch bank
  input wire dirctl_pkg::config_switch_bank_t config_switch_bank_i,
  input wire logic config_load_i,
  // host rs-232 side
  input wire logic host_txd_i,
  input wire logic host_rts_i,
  output logic host_rxd_o,
  output logic host_cts_o,
  // rs-485 side
  input wire logic line_rx_i,
  output logic line_tx_o,
  output logic line_drv_en_o,
  output logic line_rx_en_n_o,
  // indicators
  output logic ready_led_o,
  output logic driver_led_o,
  output logic rx_activity_led_o
);

  // latched configuration; rate defaults to 9600 bit/s
  dirctl_pkg::config_switch_bank_t cfg_reg;
  // bit period table in clock cycles
  logic [dirctl_pkg::CNT_W-1:0] bit_cycles [8];
  logic [dirctl_pkg::CNT_W-1:0] window_cycles;
  // driver state
  dirctl_pkg::drv_state_t drv_state_reg;
  logic drv_on;
  // edge detector outputs
  logic tx_fall, tx_edge, rx_edge;
  // timer signals
  logic drv_run, drv_exp, cts_run, cts_exp;
  // cts and serial output registers
  logic cts_reg;
  logic rx_busy_reg;
  logic host_rxd_reg;
  logic line_tx_reg;
  logic echo_eff;
  logic rx_pass;
  // ready flag, dark while reset is held
  logic ready_reg;

  // per-code bit period, rounded down so a window never overruns
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_rate
      assign bit_cycles[g] = dirctl_pkg::CNT_W'(dirctl_pkg::CLK_HZ
                             / dirctl_pkg::RATE_BPS[g]); // [R6] [R17]
    end
  endgenerate

  // ten bit periods of the chosen rate
  assign window_cycles = dirctl_pkg::CNT_W'(bit_cycles[cfg_reg.rate_code]
                         * dirctl_pkg::IDLE_BITS); // [R17]

  // configuration capture; reset holds factory defaults
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_reg.rate_code <= dirctl_pkg::RATE_CODE_RESET; // [R12]
      cfg_reg.two_wire <= dirctl_pkg::SEL_TWO_WIRE; // [R8]
      cfg_reg.manual_mode <= ~dirctl_pkg::SEL_MANUAL; // [R9]
      cfg_reg.echo_on <= ~dirctl_pkg::SEL_ECHO_ON; // [R10]
    end else if (config_load_i) begin
      cfg_reg <= config_switch_bank_i;
    end
  end

  // echo only counts in two-wire operation
  assign echo_eff = (cfg_reg.echo_on == dirctl_pkg::SEL_ECHO_ON)
                    && (cfg_reg.two_wire == dirctl_pkg::SEL_TWO_WIRE); // [R10]

  // line edge detectors
  edge_watch u_tx_watch (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .line_i(host_txd_i),
    .fall_o(tx_fall),
    .edge_o(tx_edge)
  );

  edge_watch u_rx_watch (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .line_i(line_rx_i),
    .fall_o(),
    .edge_o(rx_edge)
  );

  // driver idle timer restarts on each host data edge while in DRV_AUTO, on falling edges only otherwise
  idle_timer u_drv_timer (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .limit_i(window_cycles),
    .restart_i(drv_state_reg == dirctl_pkg::DRV_AUTO ? tx_edge : tx_fall),
    .cancel_i(cfg_reg.manual_mode == dirctl_pkg::SEL_MANUAL),
    .running_o(drv_run),
    .expire_o(drv_exp)
  ); // [R1] [R17]

  // driver state machine
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      drv_state_reg <= dirctl_pkg::DRV_IDLE;
    end else begin
      unique case (drv_state_reg)
        dirctl_pkg::DRV_IDLE: begin
          if (cfg_reg.manual_mode == dirctl_pkg::SEL_MANUAL) begin
            if (host_rts_i) begin
              drv_state_reg <= dirctl_pkg::DRV_MANUAL; // [R2]
            end
          end else if (tx_fall && !rx_busy_reg) begin
            drv_state_reg <= dirctl_pkg::DRV_AUTO; // [R1] [R7]
          end
        end
        dirctl_pkg::DRV_AUTO: begin
          // mode change or idle timeout releases the line
          if (cfg_reg.manual_mode == dirctl_pkg::SEL_MANUAL || drv_exp) begin
            drv_state_reg <= dirctl_pkg::DRV_IDLE; // [R1]
          end
        end
        dirctl_pkg::DRV_MANUAL: begin
          if (!host_rts_i ||
              cfg_reg.manual_mode != dirctl_pkg::SEL_MANUAL) begin
            drv_state_reg <= dirctl_pkg::DRV_IDLE; // [R2]
          end
        end
        default: begin
          drv_state_reg <= dirctl_pkg::DRV_IDLE;
        end
      endcase
    end
  end

  assign drv_on = (drv_state_reg != dirctl_pkg::DRV_IDLE);

  // cts holdoff timer: rs-485 edges restart while not driving, host falling edges cancel
  idle_timer u_cts_timer (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .limit_i(window_cycles),
    .restart_i(rx_edge && !drv_on), // [R4] [R17]
    .cancel_i(tx_fall), // [R5]
    .running_o(cts_run),
    .expire_o(cts_exp)
  );

  // receive busy flag follows the holdoff timer
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_busy_reg <= 1'b0;
    end else if (rx_edge && !drv_on) begin
      rx_busy_reg <= 1'b1; // [R3]
    end else if (tx_fall || cts_exp) begin
      rx_busy_reg <= 1'b0; // [R4] [R5]
    end
  end

  // cts: off on rs-485 activity; activity wins over a same-cycle release
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cts_reg <= 1'b1;
    end else if (rx_edge && !drv_on) begin
      cts_reg <= 1'b0; // [R3]
    end else if (cts_exp || (tx_fall && cts_run)) begin
      cts_reg <= 1'b1; // [R4] [R5]
    end
  end

  // ready indicator: cleared by reset, lit from the first edge after it
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ready_reg <= 1'b0;
    end else begin
      ready_reg <= 1'b1; // [R15]
    end
  end

  // receive path gate: blocked while driving unless echoing
  assign rx_pass = !drv_on || echo_eff; // [R16]

  // registered serial outputs; idle level when not passing
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      line_tx_reg <= dirctl_pkg::LINE_IDLE;
      host_rxd_reg <= dirctl_pkg::LINE_IDLE;
    end else begin
      line_tx_reg <= drv_on ? host_txd_i : dirctl_pkg::LINE_IDLE; // [R1]
      host_rxd_reg <= rx_pass ? line_rx_i : dirctl_pkg::LINE_IDLE; // [R16]
    end
  end

  // outputs
  assign line_tx_o = line_tx_reg;
  assign line_drv_en_o = drv_on; // [R1] [R2]
  assign line_rx_en_n_o = !rx_pass; // [R16]
  assign host_rxd_o = host_rxd_reg;
  assign host_cts_o = cts_reg;
  assign driver_led_o = drv_on; // [R13]
  assign rx_activity_led_o = !host_rxd_reg; // [R14]
  assign ready_led_o = ready_reg; // [R15]

  // checks
  a_manual_release: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    drv_state_reg == dirctl_pkg::DRV_MANUAL && !host_rts_i
    |=> !line_drv_en_o) else $error("driver stayed on after rts low"); // [R2]
  a_auto_start: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    drv_state_reg == dirctl_pkg::DRV_IDLE && !cfg_reg.manual_mode
    && tx_fall && !rx_busy_reg |=> line_drv_en_o)
    else $error("start bit did not enable driver"); // [R1]
  a_auto_hold: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    drv_state_reg == dirctl_pkg::DRV_AUTO && drv_run && !drv_exp
    && !cfg_reg.manual_mode |=> line_drv_en_o)
    else $error("driver dropped before idle window"); // [R1]
  a_cts_drop: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    rx_edge && !drv_on |=> !host_cts_o)
    else $error("cts not dropped on receive activity"); // [R3]
  a_cts_hold: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    !host_cts_o && cts_run && !tx_fall && !cts_exp |=> !host_cts_o)
    else $error("cts returned early"); // [R4]
  a_cts_early: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    cts_run && tx_fall && !(rx_edge && !drv_on) |=> host_cts_o)
    else $error("host data did not release cts"); // [R5]
  a_led_driver: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    driver_led_o == line_drv_en_o)
    else $error("driver indicator mismatch"); // [R13]
  a_rx_block: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    line_drv_en_o && !echo_eff |=> host_rxd_o == dirctl_pkg::LINE_IDLE)
    else $error("receive not blocked while driving"); // [R16]
  a_tx_follow: assert property (@(posedge clock_i) disable iff (!arst_n_i)
    drv_on |=> line_tx_o == $past(host_txd_i))
    else $error("transmit data not forwarded"); // [R1]

  c_auto_frame: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    drv_state_reg == dirctl_pkg::DRV_AUTO ##1 drv_exp);
  c_manual: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    drv_state_reg == dirctl_pkg::DRV_MANUAL);
  c_cts_timeout: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    !host_cts_o ##1 cts_exp);
  c_cts_early: cover property (@(posedge clock_i) disable iff (!arst_n_i)
    cts_run && tx_fall);

endmodule : dirctl_top
`default_nettype wire

// >>> dirctl_pkg.sv
// shared constants and types for the half-duplex direction controller
package dirctl_pkg;

  // clock rate and the ten-bit idle window
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned IDLE_BITS = 10;

  // rate codes
  localparam logic [2:0] RATE_CODE_RESET = 3'h5;
  localparam int unsigned RATE_BPS [8] = '{300, 600, 1200, 2400, 4800, 9600,
                                           19200, 38400};
  localparam int CNT_W = 24;

  // selector polarities, as seen on the switch bank
  localparam logic SEL_TWO_WIRE = 1'b1;
  localparam logic SEL_MANUAL = 1'b1;
  localparam logic SEL_ECHO_ON = 1'b1;

  // idle line level of the serial wires
  localparam logic LINE_IDLE = 1'b1;

  // switch bank carried as one packed word
  typedef struct packed {
    logic [2:0] rate_code;
    logic two_wire;
    logic manual_mode;
    logic echo_on;
  } config_switch_bank_t;

  // driver control states
  typedef enum logic [1:0] {DRV_IDLE, DRV_AUTO, DRV_MANUAL} drv_state_t;

endpackage : dirctl_pkg

// >>> idle_timer.sv
// ten-bit idle timer restarted on each pulse of its restart input
`timescale 1ns/1ps
`default_nettype none
module idle_timer (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // control
  input wire logic [dirctl_pkg::CNT_W-1:0] limit_i,
  input wire logic restart_i,
  input wire logic cancel_i,
  // status
  output logic running_o,
  output logic expire_o
);

  // counts down cycles of the ten-bit window
  logic [dirctl_pkg::CNT_W-1:0] count_reg;

  // count process: restart wins over cancel and expiry
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_reg <= '0;
    end else if (restart_i) begin
      count_reg <= limit_i;
    end else if (cancel_i) begin
      count_reg <= '0;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  assign running_o = (count_reg != '0);
  // one-cycle pulse when the last cycle elapses
  assign expire_o = (count_reg == {{(dirctl_pkg::CNT_W-1){1'b0}}, 1'b1})
                    && !restart_i && !cancel_i;

endmodule : idle_timer
`default_nettype wire

// >>> edge_watch.sv
// detects a level change on a serial line sampled by the clock
`timescale 1ns/1ps
`default_nettype none
module edge_watch (
  // clock and reset
  input wire logic clock_i,
  input wire logic arst_n_i,
  // line
  input wire logic line_i,
  // result
  output logic fall_o,
  output logic edge_o
);

  // previous line level, idle after reset
  logic prev_reg;

  // remember last sample
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_reg <= dirctl_pkg::LINE_IDLE;
    end else begin
      prev_reg <= line_i;
    end
  end

  assign fall_o = prev_reg && !line_i;
  assign edge_o = prev_reg != line_i;

endmodule : edge_watch
`default_nettype wire

// >>> serial_far_end.sv
// far-end serial line model: host port or rs-485 instrument
`timescale 1ns/1ps
`default_nettype none
module serial_far_end (
  // clock
  input wire logic clock_i,
  // line driven toward the block
  output logic line_o
);
  // line rests at the stop level between frames
  initial line_o = dirctl_pkg::LINE_IDLE;
  // set one level from the clock edge on
  task automatic drive(input logic v);
    @(posedge clock_i);
    line_o <= v;
  endtask : drive
  // start bit low, eight data bits lsb first, stop bit high
  task automatic send_frame(input logic [7:0] d, input int bit_cyc);
    logic [9:0] bits;
    bits = {1'b1, d, 1'b0};
    @(posedge clock_i);
    for (int i = 0; i < 10; i++) begin
      line_o <= bits[i];
      repeat (bit_cyc) @(posedge clock_i);
    end
  endtask : send_frame
endmodule : serial_far_end
`default_nettype wire

// >>> serial_half_duplex_direction_ctl_bench.sv
// self-checking bench for the direction controller
`timescale 1ns/1ps
`default_nettype none
module serial_half_duplex_direction_ctl_bench;
  logic clock_i, arst_n_i, config_load_i, host_rts_i;
  dirctl_pkg::config_switch_bank_t config_switch_bank_i;
  wire logic host_txd_i, line_rx_i;
  logic host_rxd_o, host_cts_o, line_tx_o, line_drv_en_o, line_rx_en_n_o;
  logic ready_led_o, driver_led_o, rx_activity_led_o;
  int bad_count = 0, checks = 0, seed = 65527, win;
  logic v, p;
  dirctl_top dut (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .config_switch_bank_i(config_switch_bank_i),
    .config_load_i(config_load_i), .host_txd_i(host_txd_i),
    .host_rts_i(host_rts_i), .host_rxd_o(host_rxd_o),
    .host_cts_o(host_cts_o), .line_rx_i(line_rx_i),
    .line_tx_o(line_tx_o), .line_drv_en_o(line_drv_en_o),
    .line_rx_en_n_o(line_rx_en_n_o), .ready_led_o(ready_led_o),
    .driver_led_o(driver_led_o), .rx_activity_led_o(rx_activity_led_o));
  serial_far_end host_end (.clock_i(clock_i), .line_o(host_txd_i));
  serial_far_end bus_end (.clock_i(clock_i), .line_o(line_rx_i));
  // ten bit periods in clock cycles for a rate code
  function automatic int win_cyc(input logic [2:0] c);
    return dirctl_pkg::IDLE_BITS * (dirctl_pkg::CLK_HZ /
      dirctl_pkg::RATE_BPS[c]);
  endfunction : win_cyc
  // 100 mhz clock
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  task automatic check(input string n, input logic s, input logic e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %b seen %b", n, e, s);
    end
  endtask : check
  // rising edges pass, then settle to the falling edge for sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask : tick
  task automatic load(input logic two, input logic man, input logic echo);
    @(posedge clock_i);
    config_switch_bank_i <= '{3'h7, two, man, echo};
    config_load_i <= 1'b1;
  endtask : load
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // watchdog sized past the longest idle waits
  initial begin
    #1_000_000;
    bad_count++;
    print_verdict();
  end
  initial begin
    config_switch_bank_i = '{3'h7, 1'b1, 1'b0, 1'b0};
    config_load_i = 1'b0;
    host_rts_i = 1'b0;
    arst_n_i = 1'b0;
    win = win_cyc(3'h7);
    repeat (12) @(posedge clock_i);
    check("ready", ready_led_o, 1'b0);
    arst_n_i <= 1'b1;
    tick(1);
    check("ready", ready_led_o, 1'b1);
    check("cts", host_cts_o, 1'b1);
    check("drv", line_drv_en_o, 1'b0);
    // reset rate keeps the driver well past a code-7 window
    @(posedge clock_i);
    host_end.drive(1'b0);
    tick(2);
    check("drv", line_drv_en_o, 1'b1);
    host_end.drive(1'b1);
    tick(win + 100);
    check("drv", line_drv_en_o, 1'b1);
    load(1'b1, 1'b1, 1'b0);
    tick(3);
    check("drv", line_drv_en_o, 1'b0);
    load(1'b1, 1'b0, 1'b0);
    tick(3);
    // auto start, random passthrough, then idle release
    @(posedge clock_i);
    host_end.drive(1'b0);
    tick(2);
    check("drv", line_drv_en_o, 1'b1);
    check("drv_led", driver_led_o, 1'b1);
    check("tx", line_tx_o, 1'b0);
    p = 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clock_i);
      v = (i == 39) ? 1'b1 : (i == 38) ? 1'b0 : 1'($random(seed));
      host_end.drive(v);
      @(negedge clock_i);
      check("tx", line_tx_o, p);
      p = v;
    end
    tick(win - 10);
    check("drv", line_drv_en_o, 1'b1);
    tick(20);
    check("drv", line_drv_en_o, 1'b0);
    check("drv_led", driver_led_o, 1'b0);
    check("tx", line_tx_o, 1'b1);
    // receive activity drops cts, returns after the window
    @(posedge clock_i);
    bus_end.drive(1'b0);
    tick(2);
    check("cts", host_cts_o, 1'b0);
    check("rxd", host_rxd_o, 1'b0);
    check("rx_led", rx_activity_led_o, 1'b1);
    bus_end.send_frame(8'ha5, 4);
    tick(win - 10);
    check("cts", host_cts_o, 1'b0);
    check("rx_led", rx_activity_led_o, 1'b0);
    tick(20);
    check("cts", host_cts_o, 1'b1);
    // host data during holdoff returns cts at once
    bus_end.send_frame(8'h3c, 4);
    tick(50);
    check("cts", host_cts_o, 1'b0);
    host_end.drive(1'b0);
    tick(3);
    check("cts", host_cts_o, 1'b1);
    host_end.drive(1'b1);
    // manual mode, random topology with echo kept off, then echo on
    load(1'($random(seed)), 1'b1, 1'b0);
    host_rts_i <= 1'b1;
    tick(3);
    check("drv", line_drv_en_o, 1'b1);
    check("rx_en_n", line_rx_en_n_o, 1'b1);
    for (int k = 0; k < 2; k++) begin
      if (k == 1) begin
        load(1'b1, 1'b1, 1'b1);
        tick(3);
        check("rx_en_n", line_rx_en_n_o, 1'b0);
      end
      p = 1'b1;
      for (int i = 0; i < 30; i++) begin
        @(posedge clock_i);
        v = (i == 29) ? 1'b1 : 1'($random(seed));
        bus_end.drive(v);
        @(negedge clock_i);
        check("rxd", host_rxd_o, k ? p : 1'b1);
        p = v;
      end
    end
    check("drv", line_drv_en_o, 1'b1);
    @(posedge clock_i);
    host_rts_i <= 1'b0;
    tick(2);
    check("drv", line_drv_en_o, 1'b0);
    check("drv_led", driver_led_o, 1'b0);
    print_verdict();
  end
endmodule : serial_half_duplex_direction_ctl_bench
`default_nettype wire
